/* hdl/frame_shifter.sv */
// sixteen-bit shift register used by the register bank end, once for each direction
`timescale 1ns/1ns
`default_nettype none
module frame_shifter #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             shift,
  input  wire logic             serial_in,
  output logic [WIDTH-1:0]      value_q
);
  // lsb goes out first so command bit 0 leads the frame
  always_ff @(posedge core_clk)
  begin
    if (rst)
      value_q <= '0;
    else if (load)
      value_q <= load_value;
    else if (shift)
      value_q <= {serial_in, value_q[WIDTH-1:1]};
  end
endmodule : frame_shifter
`default_nettype wire

/* hdl/regbank_consts.svh */
// constants for the mode and supply register bank and its serial link
`ifndef REGBANK_CONSTS_SVH
`define REGBANK_CONSTS_SVH
// ****************************************************************
// command frame layout
// ****************************************************************
`define FRAME_BITS        16
`define ACCESS_BIT        7
`define ADDR_MSB          6
`define DATA_LSB          8
`define DATA_MSB          15
// ****************************************************************
// register addresses
// ****************************************************************
`define ADDR_MODE_SUPPLY  7'h01
`define ADDR_WAKE_CTRL_B  7'h07
// ****************************************************************
// mode and supply register fields and values
// ****************************************************************
`define MODE_MSB          7
`define MODE_LSB          6
`define RSVD_BIT          5
`define AUX_MSB           4
`define AUX_LSB           3
`define OV_RST_BIT        2
`define THR_MSB           1
`define THR_LSB           0
`define MODE_SUPPLY_RESET 8'h00
`define RESTART_KEEP_MASK 8'h07
`define WAKE_B_RESET      8'h00
// ****************************************************************
// controller register offsets (axi4-lite byte addresses)
// ****************************************************************
`define CTL_CMD           4'h0
`define CTL_DATA          4'h4
`define CTL_STATUS        4'h8
// ****************************************************************
// serial clock divider
// ****************************************************************
`define SCLK_DIV          8'h04
`endif

/* hdl/regbank_controller.sv */
// host end: axi4-lite registers driving sixteen-bit frames
`include "regbank_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module regbank_controller #(
  parameter logic [7:0] DIV = `SCLK_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  serial_link_if.controller link,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  logic [15:0] cmd_q;
  logic [7:0]  reply_q;
  logic        busy_q;
  logic        done_q;
  logic [4:0]  cnt_q;
  logic [7:0]  div_q;
  logic        tick;
  logic        aw_q;
  logic        w_q;
  logic [3:0]  awa_q;
  logic [31:0] wd_q;
  logic        start;

  // ****************************************************************
  // axi4-lite write: address and data taken in either order
  // ****************************************************************
  assign awready = !aw_q && !bvalid;
  assign wready  = !w_q && !bvalid;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_q  <= 1'b0;
      w_q   <= 1'b0;
      awa_q <= 4'h0;
      wd_q  <= 32'h0000_0000;
    end
    else if (aw_q && w_q)
    begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_q  <= 1'b1;
        awa_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_q  <= 1'b1;
        wd_q <= wdata;
      end
    end
  end

  // writes to the command word while busy are dropped
  logic wstrb_ok_q;
  assign start = aw_q && w_q && awa_q == `CTL_CMD && !busy_q && wstrb_ok_q;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wstrb_ok_q <= 1'b0;
    else if (wvalid && wready)
      wstrb_ok_q <= wstrb[0] && wstrb[1];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= 2'b00;
    end
    else if (aw_q && w_q)
    begin
      bvalid <= 1'b1;
      bresp  <= (awa_q == `CTL_CMD) ? 2'b00 : 2'b10;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ****************************************************************
  // axi4-lite read
  // ****************************************************************
  assign arready = !rvalid;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= 2'b00;
      case (araddr)
        `CTL_CMD:    rdata <= {16'h0000, cmd_q};
        `CTL_DATA:   rdata <= {24'h00_0000, reply_q};
        `CTL_STATUS: rdata <= {30'h0000_0000, done_q, busy_q};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= 2'b10;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ****************************************************************
  // frame engine
  // ****************************************************************
  assign tick = busy_q && div_q == DIV - 8'h01;
  always_ff @(posedge core_clk)
  begin
    if (rst || !busy_q || tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= 5'h00;
      cmd_q   <= 16'h0000;
      reply_q <= 8'h00;
    end
    else if (start)
    begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      cnt_q  <= 5'h00;
      cmd_q  <= wd_q[15:0];                                       // RL1 RL4
    end
    else if (tick)
    begin
      if (cnt_q == 5'(`FRAME_BITS))
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q >= 5'h08)
          reply_q <= {link.miso, reply_q[7:1]};
      end
    end
  end

  // host owns every change of control bits and rebuilds the word itself
  assign link.chip_select_low = !busy_q || cnt_q == 5'(`FRAME_BITS); // RL8
  assign link.sclk_en         = tick && cnt_q < 5'(`FRAME_BITS);
  assign link.mosi            = cmd_q[cnt_q[3:0]];               // RL2 RL3 RL17
endmodule : regbank_controller
`default_nettype wire

/* hdl/regbank_device.sv */
// register bank end: decodes frames and holds the mode and supply byte
// ****************************************************************
// Contract
// RL1 - frames are sixteen bits, address then data
// RL2 - access bit zero only reads
// RL3 - access bit one writes whole byte
// RL4 - data bits map onto frame bits 8-15
// RL5 - power-on or soft reset loads reset values
// RL6 - restart loads restart value, keeps don't-cares
// RL7 - read-only bits ignore writes
// RL8 - host rewrites control bits itself
// RL9 - mode and supply register at address one
// RL10 - reset zero, restart clears bits 7-3
// RL11 - mode field selects normal sleep stop reset
// RL12 - bit five reads zero
// RL13 - aux supply field selects on modes
// RL14 - overvoltage reset only when enabled
// RL15 - threshold field picks level or disables
// RL16 - sleep without wake source means restart
// RL17 - status clears only with access bit set
// RL18 - new setting visible on next frame
// RL19 - commands ignored in restart or sleep
// RL20 - unmapped addresses read zero, write nothing
// ****************************************************************
`include "regbank_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module regbank_device (
  input  wire logic       core_clk,
  input  wire logic       rst,
  serial_link_if.device   link,
  input  wire logic       restart_done,
  input  wire logic       wake_event,
  input  wire logic       main_overvoltage,
  input  wire logic       main_undervoltage,
  input  wire logic [7:0] status_flags,
  output logic [1:0]      op_mode,
  output logic [1:0]      aux_supply_select,
  output logic            aux_supply_on,
  output logic            main_overvoltage_reset_enable,
  output logic [1:0]      main_reset_threshold,
  output logic            reset_output_pin,
  output logic            soft_reset_pulse,
  output logic [1:0]      dev_state,
  output logic [7:0]      status_q
);
  logic [7:0]  mode_supply_q;
  logic [7:0]  wake_b_q;
  logic [15:0] rx_value;
  logic [15:0] tx_value;
  logic [15:0] reply_q;
  logic [4:0]  bit_cnt_q;
  logic        csl_q;
  logic        frame_end;
  logic        frame_ok;
  logic        is_write;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        restart_req;
  regbank_pkg::dev_state_type state_q;
  regbank_pkg::dev_state_type state_d;

  // ****************************************************************
  // read decode
  // ****************************************************************
  function automatic logic [7:0] read_byte(input logic [6:0] a,
                                           input logic [7:0] ms,
                                           input logic [7:0] wb,
                                           input logic [7:0] st);
    logic [7:0] r;
    r = 8'h00;
    if (a == `ADDR_MODE_SUPPLY)                                   // RL9
      r = ms & ~(8'h01 << `RSVD_BIT);                              // RL12
    else if (a == `ADDR_WAKE_CTRL_B)
      r = wb;
    else if (a[6])
      r = st;
    return r;                                                     // RL20
  endfunction : read_byte

  // ****************************************************************
  // frame capture
  // ****************************************************************
  frame_shifter #(
    .WIDTH (`FRAME_BITS)
  ) rx_shift (
    .core_clk   (core_clk),
    .rst        (rst),
    .load       (1'b0),
    .load_value (16'h0000),
    .shift      (link.sclk_en && !link.chip_select_low),
    .serial_in  (link.mosi),
    .value_q    (rx_value)
  );

  always_ff @(posedge core_clk)
  begin
    if (rst)
      csl_q <= 1'b1;
    else
      csl_q <= link.chip_select_low;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || link.chip_select_low)
      bit_cnt_q <= 5'h00;
    else if (link.sclk_en && bit_cnt_q != 5'h1f)
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  assign frame_end = link.chip_select_low && !csl_q;
  // partial frames are discarded whole
  assign frame_ok  = frame_end && (bit_cnt_q == 5'(`FRAME_BITS)); // RL1
  assign addr      = rx_value[`ADDR_MSB:0];
  assign is_write  = rx_value[`ACCESS_BIT];                       // RL2 RL3
  assign wdata     = rx_value[`DATA_MSB:`DATA_LSB];               // RL4
  // after seven strobes the address sits in the top seven bits
  assign rdata     = read_byte(rx_value[`FRAME_BITS-1:`DATA_LSB+1],
                               mode_supply_q, wake_b_q, status_q);

  // ****************************************************************
  // reply: shows contents as they stood at the address boundary, after seven strobes
  // ****************************************************************
  frame_shifter #(
    .WIDTH (`FRAME_BITS)
  ) tx_shift (
    .core_clk   (core_clk),
    .rst        (rst),
    .load       (link.sclk_en && bit_cnt_q == 5'h07),              // RL18
    .load_value (tx_value),
    .shift      (link.sclk_en),
    .serial_in  (1'b0),
    .value_q    (reply_q)
  );
  // reply byte latched at the address boundary so a write in this frame
  // shows only on the next one; its lsb stands on miso for data bit 0
  assign tx_value  = {8'h00, rdata};
  assign link.miso = reply_q[0];

  // ****************************************************************
  // operating state
  // ****************************************************************
  assign restart_req = (main_overvoltage && mode_supply_q[`OV_RST_BIT])
                       || (main_undervoltage &&
                           mode_supply_q[`THR_MSB:`THR_LSB] != 2'b11);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      regbank_pkg::DEV_RUN,
      regbank_pkg::DEV_STOP:
      begin
        if (restart_req)                                          // RL14 RL15
          state_d = regbank_pkg::DEV_RESTART;
        else if (frame_ok && is_write && addr == `ADDR_MODE_SUPPLY)
        begin
          case (wdata[`MODE_MSB:`MODE_LSB])                       // RL11
            2'b01: state_d = (wake_b_q == 8'h00) ?
                             regbank_pkg::DEV_RESTART :           // RL16
                             regbank_pkg::DEV_SLEEP;
            2'b10: state_d = regbank_pkg::DEV_STOP;
            default: state_d = regbank_pkg::DEV_RUN;
          endcase
        end
      end
      regbank_pkg::DEV_RESTART:
        if (restart_done)
          state_d = regbank_pkg::DEV_RUN;
      regbank_pkg::DEV_SLEEP:
        if (wake_event)
          state_d = regbank_pkg::DEV_RESTART;
      default: state_d = regbank_pkg::DEV_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_q <= regbank_pkg::DEV_RUN;
    else
      state_q <= state_d;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic accept;
  logic soft_rst;
  assign accept   = frame_ok && (state_q == regbank_pkg::DEV_RUN ||
                                 state_q == regbank_pkg::DEV_STOP); // RL19
  assign soft_rst = accept && is_write && addr == `ADDR_MODE_SUPPLY &&
                    wdata[`MODE_MSB:`MODE_LSB] == 2'b11;          // RL11

  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)                                          // RL5
      mode_supply_q <= `MODE_SUPPLY_RESET;                        // RL10
    else if (state_d == regbank_pkg::DEV_RESTART &&
             state_q != regbank_pkg::DEV_RESTART)
      mode_supply_q <= mode_supply_q & `RESTART_KEEP_MASK;        // RL6 RL10
    else if (accept && is_write && addr == `ADDR_MODE_SUPPLY)     // RL3
      mode_supply_q <= wdata & ~(8'h01 << `RSVD_BIT);             // RL7
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || soft_rst)
      wake_b_q <= `WAKE_B_RESET;
    else if (accept && is_write && addr == `ADDR_WAKE_CTRL_B)
      wake_b_q <= wdata;
  end

  // set wins over clear for every status flag
  always_ff @(posedge core_clk)
  begin
    if (rst)
      status_q <= 8'h00;
    else if (accept && is_write && addr[6])                       // RL17
      status_q <= status_flags;
    else
      status_q <= status_q | status_flags;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      soft_reset_pulse <= 1'b0;
    else
      soft_reset_pulse <= soft_rst;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      reset_output_pin <= 1'b0;
    else
      reset_output_pin <= (state_q == regbank_pkg::DEV_RESTART);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      aux_supply_on <= 1'b0;
    else
      case (mode_supply_q[`AUX_MSB:`AUX_LSB])                     // RL13
        2'b01: aux_supply_on <= state_q == regbank_pkg::DEV_RUN;
        2'b10: aux_supply_on <= state_q == regbank_pkg::DEV_RUN ||
                                state_q == regbank_pkg::DEV_STOP;
        2'b11: aux_supply_on <= state_q != regbank_pkg::DEV_RESTART;
        default: aux_supply_on <= 1'b0;
      endcase
  end

  assign op_mode                       = mode_supply_q[`MODE_MSB:`MODE_LSB];
  assign aux_supply_select             = mode_supply_q[`AUX_MSB:`AUX_LSB];
  assign main_overvoltage_reset_enable = mode_supply_q[`OV_RST_BIT];
  assign main_reset_threshold          = mode_supply_q[`THR_MSB:`THR_LSB];
  assign dev_state                     = state_q;
endmodule : regbank_device
`default_nettype wire

/* hdl/regbank_pkg.sv */
// types shared by the register bank end of the link and the bench
package regbank_pkg;
  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP  = 2'b01,
    MODE_STOP   = 2'b10,
    MODE_SOFT_RESET = 2'b11
  } op_mode_type;
  typedef enum logic [1:0]
  {
    DEV_RUN     = 2'b00,
    DEV_RESTART = 2'b01,
    DEV_SLEEP   = 2'b10,
    DEV_STOP    = 2'b11
  } dev_state_type;
endpackage : regbank_pkg

/* hdl/serial_link_if.sv */
// serial link between controller and register bank
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if;
  logic chip_select_low;
  logic sclk_en;
  logic mosi;
  logic miso;
  modport controller
  (
    output chip_select_low,
    output sclk_en,
    output mosi,
    input  miso
  );
  modport device
  (
    input  chip_select_low,
    input  sclk_en,
    input  mosi,
    output miso
  );
endinterface : serial_link_if
`default_nettype wire

/* testbench/regbank_link_monitor.sv */
// concurrent checks on the serial link and the device outputs
`timescale 1ns/1ns
`default_nettype none
module regbank_link_monitor (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       chip_select_low,
  input wire logic       sclk_en,
  input wire logic       main_overvoltage,
  input wire logic [1:0] op_mode,
  input wire logic [1:0] aux_supply_select,
  input wire logic       main_overvoltage_reset_enable,
  input wire logic [1:0] main_reset_threshold,
  input wire logic       reset_output_pin,
  input wire logic       soft_reset_pulse,
  input wire logic [1:0] dev_state
);
  // ********************
  // helpers
  // ********************
  logic [4:0] bits_q;
  logic [2:0] recent_q;
  logic       rs;
  assign rs = (dev_state == regbank_pkg::DEV_RESTART);
  always_ff @(posedge core_clk)
  begin
    if (rst || chip_select_low)
      bits_q <= 5'h00;
    else if (sclk_en)
      bits_q <= bits_q + 5'h01;
  end
  // window after a frame end in which control fields may move
  always_ff @(posedge core_clk)
  begin
    if (rst)
      recent_q <= 3'h0;
    else if ($rose(chip_select_low))
      recent_q <= 3'h7;
    else if (recent_q != 3'h0)
      recent_q <= recent_q - 3'h1;
  end
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence strobe_gap;
    !sclk_en [*3];
  endsequence
  sequence restart_settled;
    rs && $past(rs) && $past(rs, 2);
  endsequence
  a_idle_no_strobe: assert property (chip_select_low |-> !sclk_en)
    else $error("bit strobe while idle");
  a_frame_sixteen: assert property ($rose(chip_select_low) |-> bits_q == 5'h10)
    else $error("frame not sixteen bits");
  a_strobe_gap_kept: assert property (sclk_en |=> strobe_gap)
    else $error("bit strobes too close");
  a_reset_clears_fields: assert property ($fell(rst) |-> op_mode == 2'b00 &&
    aux_supply_select == 2'b00 && !main_overvoltage_reset_enable &&
    main_reset_threshold == 2'b00) else $error("fields not zero after reset");
  a_soft_reset_quiet: assert property (soft_reset_pulse |-> !reset_output_pin ##1 !reset_output_pin)
    else $error("soft reset drove reset pin");
  a_ov_restart: assert property (main_overvoltage && main_overvoltage_reset_enable &&
    dev_state == regbank_pkg::DEV_RUN |-> ##[1:4] rs) else $error("no restart on overvoltage");
  a_restart_clears_upper: assert property ($rose(rs) |-> ##[0:2] (op_mode == 2'b00 &&
    aux_supply_select == 2'b00)) else $error("restart kept upper bits");
  a_threshold_by_frame: assert property ($changed(main_reset_threshold) |-> recent_q != 3'h0)
    else $error("threshold moved without a frame");
  a_restart_ignores: assert property (restart_settled |=> $stable(aux_supply_select) || !rs)
    else $error("field changed in restart");
endmodule : regbank_link_monitor
`default_nettype wire

/* testbench/sbc_spi_mode_supply_regs_tb_top.sv */
// bench joining controller and register bank over the serial link
`include "regbank_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, (e), (g)); end end
module sbc_spi_mode_supply_regs_tb_top;
  logic        core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, op_mode, aux_supply_select, main_reset_threshold;
  logic        restart_done, wake_event, main_overvoltage, main_undervoltage;
  logic        aux_supply_on, main_overvoltage_reset_enable, reset_output_pin;
  logic        soft_reset_pulse;
  logic [1:0]  dev_state;
  logic [7:0]  status_flags, status_q;
  int          num_errors, num_checks, cycles;
  serial_link_if u_serial_link_if ();
  regbank_controller u_regbank_controller (.core_clk, .rst, .link(u_serial_link_if),
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  regbank_device u_regbank_device (.core_clk, .rst, .link(u_serial_link_if),
    .restart_done, .wake_event, .main_overvoltage, .main_undervoltage, .status_flags,
    .op_mode, .aux_supply_select, .aux_supply_on, .main_overvoltage_reset_enable,
    .main_reset_threshold, .reset_output_pin, .soft_reset_pulse, .dev_state, .status_q);
  regbank_link_monitor u_regbank_link_monitor (.core_clk, .rst,
    .chip_select_low(u_serial_link_if.chip_select_low),
    .sclk_en(u_serial_link_if.sclk_en), .main_overvoltage, .op_mode, .aux_supply_select,
    .main_overvoltage_reset_enable, .main_reset_threshold, .reset_output_pin,
    .soft_reset_pulse, .dev_state);
  // ********************
  // bus and frame tasks
  // ********************
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(awvalid && awready || !awvalid) || !(wvalid && wready || !wvalid));
    while (bvalid !== 1'b1) @(posedge core_clk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // one frame; the reply byte is skipped where it is meaningless
  task automatic xfer(input logic [15:0] c, input logic [7:0] e, input bit chk = 1'b1);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    axi_wr(`CTL_CMD, {16'h0000, c}, r);
    n = 0;
    do begin axi_rd(`CTL_STATUS, d, r); n++; end while (d[0] !== 1'b1 && n < 8);
    do axi_rd(`CTL_STATUS, d, r); while (d[0] !== 1'b0);
    axi_rd(`CTL_DATA, d, r);
    if (chk) `CHK("reply", e, d[7:0])
  endtask : xfer
  task automatic wait_dev(input logic [1:0] s);
    int n;
    n = 0;
    while (dev_state !== s && n < 50) begin @(posedge core_clk); n++; end
    `CHK("dev_state", s, dev_state)
  endtask : wait_dev
  // ********************
  // scenarios
  // ********************
  task automatic t_fields();
    xfer(16'h0001, 8'h00);
    xfer(16'h3F81, 8'h00);
    xfer(16'hFF01, 8'h1F);
    xfer(16'h0001, 8'h1F);
    `CHK("ov_en", 1'b1, main_overvoltage_reset_enable)
    for (int i = 0; i < 4; i++)
    begin
      xfer({3'b000, i[1:0], 1'b0, i[1:0], 8'h81}, 8'h00, 1'b0);
      `CHK("aux", i[1:0], aux_supply_select)
      `CHK("aux_on", (i != 0), aux_supply_on)
      `CHK("thr", i[1:0], main_reset_threshold)
    end
    xfer(16'hAA85, 8'h00);
    xfer(16'h0005, 8'h00);
    xfer(16'h0001, 8'h1B);
  endtask : t_fields
  task automatic t_axi_err();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(4'hC, d, r);
    `CHK("rd_resp", 2'b10, r)
    `CHK("rd_data", 32'h0000_0000, d)
    axi_wr(`CTL_STATUS, 32'h0000_0000, r);
    `CHK("wr_resp", 2'b10, r)
  endtask : t_axi_err
  task automatic t_status();
    status_flags <= 8'h05;
    @(posedge core_clk);
    status_flags <= 8'h00;
    xfer(16'h0041, 8'h05);
    xfer(16'h0041, 8'h05);
    status_flags <= 8'h02;
    xfer(16'h00C1, 8'h07);
    status_flags <= 8'h00;
    xfer(16'h0041, 8'h02);
    `CHK("status_q", 8'h02, status_q)
  endtask : t_status
  task automatic t_overvoltage();
    {main_overvoltage, main_undervoltage} <= 2'b11;
    repeat (10) @(posedge core_clk);
    `CHK("no_restart", regbank_pkg::DEV_RUN, dev_state)
    {main_overvoltage, main_undervoltage} <= 2'b00;
    xfer(16'h1681, 8'h00, 1'b0);
    main_overvoltage <= 1'b1;
    wait_dev(regbank_pkg::DEV_RESTART);
    @(posedge core_clk);
    `CHK("reset_pin", 1'b1, reset_output_pin)
    main_overvoltage <= 1'b0;
    xfer(16'hF881, 8'h00, 1'b0);
    restart_done <= 1'b1;
    wait_dev(regbank_pkg::DEV_RUN);
    restart_done <= 1'b0;
    xfer(16'h0001, 8'h06);
    main_undervoltage <= 1'b1;
    wait_dev(regbank_pkg::DEV_RESTART);
    main_undervoltage <= 1'b0;
    restart_done <= 1'b1;
    wait_dev(regbank_pkg::DEV_RUN);
    restart_done <= 1'b0;
  endtask : t_overvoltage
  task automatic t_modes();
    xfer(16'h8081, 8'h00, 1'b0);
    wait_dev(regbank_pkg::DEV_STOP);
    `CHK("op_mode", 2'b10, op_mode)
    xfer(16'h0081, 8'h00, 1'b0);
    wait_dev(regbank_pkg::DEV_RUN);
    xfer(16'h4081, 8'h00, 1'b0);
    wait_dev(regbank_pkg::DEV_RESTART);
    restart_done <= 1'b1;
    wait_dev(regbank_pkg::DEV_RUN);
    restart_done <= 1'b0;
    xfer(16'h1B81, 8'h00, 1'b0);
    xfer(16'hC081, 8'h00, 1'b0);
    xfer(16'h0001, 8'h00);
    `CHK("reset_pin", 1'b0, reset_output_pin)
    xfer(16'h0187, 8'h00, 1'b0);
    xfer(16'h4081, 8'h00, 1'b0);
    wait_dev(regbank_pkg::DEV_SLEEP);
    xfer(16'h8081, 8'h00, 1'b0);
    wake_event <= 1'b1;
    repeat (5) @(posedge core_clk);
    wake_event <= 1'b0;
    `CHK("not_stop", 1'b1, dev_state !== regbank_pkg::DEV_STOP)
  endtask : t_modes
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  // ********************
  // clock, watchdog, sequence
  // ********************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // a hang ends the run as a failure
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      stop_test();
    end
  end
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0000_0000, 4'hf};
    {restart_done, wake_event, main_overvoltage, main_undervoltage} = 4'h0;
    status_flags = 8'h00;
    {num_errors, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_fields();
    t_axi_err();
    t_status();
    t_overvoltage();
    t_modes();
    stop_test();
  end
endmodule : sbc_spi_mode_supply_regs_tb_top
`default_nettype wire
